/* hdl/pmic_classifier.sv */
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pmic_classifier
  import pmic_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic PKT_VALID_I,
  output logic PKT_READY_O,
  input wire logic PKT_POSTED_MWR_I,
  input wire logic PKT_ADDR_MSG_I,
  input wire logic [63:0] PKT_ADDR_I,
  input wire logic [1:0] PKT_AT_I,
  input wire logic [127:0] PKT_HDR_I,
  input wire logic PKT_ACS_SV_FAIL_I,
  input wire logic PKT_ERR_I,
  input wire logic OTHERS_ACCEPT_I,
  output logic OUT_VALID_O,
  output logic [63:0] OUT_ADDR_O,
  output logic OUT_IS_MCAST_O,
  output logic [5:0] OUT_GROUP_O,
  output logic OUT_UNICAST_O,
  output logic OUT_MCAST_FWD_O,
  output logic OUT_BLOCKED_O,
  output logic OUT_ACS_FAIL_O,
  output logic OUT_ERR_O,
  output logic OUT_SILENT_DROP_O,
  output logic OUT_DROP_O,
  output logic CREDIT_RETURN_O,
  output logic AER_MC_BLOCKED_O,
  output logic [127:0] HDR_LOG_O,
  input wire logic EG_VALID_I,
  input wire logic [5:0] EG_GROUP_I,
  input wire logic EG_FROM_SELF_I,
  output logic EG_DONE_O,
  output logic EG_ACCEPT_O
);

  logic [5:0] max_group_capacity;
  logic [5:0] enabled_group_count;
  logic multicast_global_enable;
  logic [5:0] group_index_position;
  logic [31:PMIC_BASE_LO_POS] group_base_low;
  logic [31:0] group_base_high;
  logic [63:0] group_block_all_bits;
  logic [63:0] group_block_untranslated_bits;
  logic [63:0] group_receive_vector;
  logic function_multicast_enable;
  logic port_is_upstream;
  logic [1:0] status_reg;
  logic [15:0] blocked_count_reg;

  logic wr_en, rd_en, addr_ok;
  logic [31:0] rd_data;
  logic [63:0] base_addr, low_mask, grp_mask, masked_addr;
  logic [5:0] fill, grp_id;
  logic cand, base_hit, in_range, mc_hit, acs_fail;
  logic blk_all, blk_ut, blocked, mc_clean;

  // apb strobes; slave answers in the access cycle
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_en = PSEL_I && PENABLE_I && !PWRITE_I;
  assign PREADY_O = 1'b1;
  assign PKT_READY_O = 1'b1; // one result per cycle, never stalls

  // address decode and read mux
  always_comb begin
    addr_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (PADDR_I)
      PMIC_OFF_CAP: rd_data[5:0] = max_group_capacity;
      PMIC_OFF_CTL: begin
        rd_data[5:0] = enabled_group_count;
        rd_data[PMIC_CTL_EN_BIT] = multicast_global_enable;
      end
      PMIC_OFF_BASE_LO: begin
        rd_data[5:0] = group_index_position;
        rd_data[31:PMIC_BASE_LO_POS] = group_base_low;
      end
      PMIC_OFF_BASE_HI: rd_data = group_base_high;
      PMIC_OFF_BLKALL_LO: rd_data = group_block_all_bits[31:0];
      PMIC_OFF_BLKALL_HI: rd_data = group_block_all_bits[63:32];
      PMIC_OFF_BLKUT_LO: rd_data = group_block_untranslated_bits[31:0];
      PMIC_OFF_BLKUT_HI: rd_data = group_block_untranslated_bits[63:32];
      PMIC_OFF_RCV_LO: rd_data = group_receive_vector[31:0];
      PMIC_OFF_RCV_HI: rd_data = group_receive_vector[63:32];
      PMIC_OFF_FUNC: begin
        rd_data[PMIC_FUNC_EN_BIT] = function_multicast_enable;
        rd_data[PMIC_FUNC_UP_BIT] = port_is_upstream;
      end
      PMIC_OFF_STATUS: rd_data[1:0] = status_reg;
      PMIC_OFF_BLKCNT: rd_data[15:0] = blocked_count_reg;
      default: addr_ok = 1'b0;
    endcase
  end

  // read data and error answer
  always_comb begin
    PRDATA_O = rd_en ? rd_data : 32'h0000_0000;
    PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;
  end

  // capability: 32 groups after reset, up to 64 by reprogramming
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      max_group_capacity <= PMIC_CAP_RST;
    end else if (wr_en && PADDR_I == PMIC_OFF_CAP) begin
      max_group_capacity <= PWDATA_I[5:0];
    end
  end

  // control and base registers; changed only with traffic quiet
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      enabled_group_count <= PMIC_NG_RST;
      multicast_global_enable <= 1'b0;
      group_index_position <= PMIC_IDX_RST;
      group_base_low <= '0;
      group_base_high <= 32'h0000_0000;
    end else if (wr_en) begin
      if (PADDR_I == PMIC_OFF_CTL) begin
        enabled_group_count <= PWDATA_I[5:0];
        multicast_global_enable <= PWDATA_I[PMIC_CTL_EN_BIT];
      end
      if (PADDR_I == PMIC_OFF_BASE_LO) begin
        group_index_position <= PWDATA_I[5:0];
        group_base_low <= PWDATA_I[31:PMIC_BASE_LO_POS];
      end
      if (PADDR_I == PMIC_OFF_BASE_HI) begin
        group_base_high <= PWDATA_I;
      end
    end
  end

  // per-group block and receive vectors
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      group_block_all_bits <= 64'h0;
      group_block_untranslated_bits <= 64'h0;
      group_receive_vector <= 64'h0;
    end else if (wr_en) begin
      case (PADDR_I)
        PMIC_OFF_BLKALL_LO: group_block_all_bits[31:0] <= PWDATA_I;
        PMIC_OFF_BLKALL_HI: group_block_all_bits[63:32] <= PWDATA_I;
        PMIC_OFF_BLKUT_LO: group_block_untranslated_bits[31:0] <= PWDATA_I;
        PMIC_OFF_BLKUT_HI: group_block_untranslated_bits[63:32] <= PWDATA_I;
        PMIC_OFF_RCV_LO: group_receive_vector[31:0] <= PWDATA_I;
        PMIC_OFF_RCV_HI: group_receive_vector[63:32] <= PWDATA_I;
        default: ;
      endcase
    end
  end

  // function enable and port direction
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      function_multicast_enable <= 1'b0;
      port_is_upstream <= 1'b0;
    end else if (wr_en && PADDR_I == PMIC_OFF_FUNC) begin
      function_multicast_enable <= PWDATA_I[PMIC_FUNC_EN_BIT];
      port_is_upstream <= PWDATA_I[PMIC_FUNC_UP_BIT];
    end
  end

  // 64-bit base from both halves
  assign base_addr = {group_base_high, group_base_low, 12'h000};

  // group field width is the bit length of the count field
  always_comb begin
    fill = enabled_group_count;
    fill = fill | (fill >> 1);
    fill = fill | (fill >> 2);
    fill = fill | (fill >> 4);
  end

  // region math: size 2^index, groups stacked from zero
  always_comb begin
    low_mask = (64'h1 << group_index_position) - 64'h1;
    grp_mask = {58'h0, fill} << group_index_position;
    masked_addr = PKT_ADDR_I & ~(low_mask | grp_mask);
    grp_id = 6'((PKT_ADDR_I >> group_index_position)) & fill;
  end

  // classification
  assign cand = PKT_POSTED_MWR_I || PKT_ADDR_MSG_I;
  assign base_hit = masked_addr == base_addr;
  assign in_range = grp_id <= enabled_group_count;
  assign mc_hit = multicast_global_enable && cand && base_hit && in_range;

  // ingress checks: source validation first, then block bits
  assign acs_fail = mc_hit && PKT_ACS_SV_FAIL_I;
  assign blk_all = group_block_all_bits[grp_id];
  assign blk_ut = group_block_untranslated_bits[grp_id] && PKT_AT_I == PMIC_AT_UNTRANSLATED;
  assign blocked = mc_hit && !acs_fail && (blk_all || blk_ut);
  assign mc_clean = mc_hit && !acs_fail && !blocked && !PKT_ERR_I;

  // one-stage result pipe keeps arrival order
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      OUT_VALID_O <= 1'b0;
      OUT_ADDR_O <= 64'h0;
      OUT_GROUP_O <= 6'h00;
    end else begin
      OUT_VALID_O <= PKT_VALID_I;
      if (PKT_VALID_I) begin
        OUT_ADDR_O <= PKT_ADDR_I;
        OUT_GROUP_O <= mc_hit ? grp_id : 6'h00;
      end
    end
  end

  // routing decision flags, one cycle per packet
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      OUT_IS_MCAST_O <= 1'b0;
      OUT_UNICAST_O <= 1'b0;
      OUT_MCAST_FWD_O <= 1'b0;
      OUT_ACS_FAIL_O <= 1'b0;
      OUT_ERR_O <= 1'b0;
      OUT_SILENT_DROP_O <= 1'b0;
    end else begin
      OUT_IS_MCAST_O <= PKT_VALID_I && mc_hit;
      OUT_UNICAST_O <= PKT_VALID_I && !mc_hit;
      OUT_MCAST_FWD_O <= PKT_VALID_I && mc_clean && OTHERS_ACCEPT_I;
      OUT_ACS_FAIL_O <= PKT_VALID_I && acs_fail;
      OUT_ERR_O <= PKT_VALID_I && PKT_ERR_I;
      OUT_SILENT_DROP_O <= PKT_VALID_I && mc_clean && !OTHERS_ACCEPT_I;
    end
  end

  // blocked handling: drop, credits back, error report
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      OUT_BLOCKED_O <= 1'b0;
      OUT_DROP_O <= 1'b0;
      CREDIT_RETURN_O <= 1'b0;
      AER_MC_BLOCKED_O <= 1'b0;
    end else begin
      OUT_BLOCKED_O <= PKT_VALID_I && blocked;
      OUT_DROP_O <= PKT_VALID_I && (blocked || (mc_clean && !OTHERS_ACCEPT_I));
      CREDIT_RETURN_O <= PKT_VALID_I && blocked;
      AER_MC_BLOCKED_O <= PKT_VALID_I && blocked;
    end
  end

  // header log holds the last blocked header
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      HDR_LOG_O <= 128'h0;
    end else if (PKT_VALID_I && blocked) begin
      HDR_LOG_O <= PKT_HDR_I;
    end
  end

  // target abort flags, write one to clear, set beats clear
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      status_reg <= 2'h0;
    end else begin
      if (wr_en && PADDR_I == PMIC_OFF_STATUS) begin
        status_reg <= status_reg & ~PWDATA_I[1:0];
      end
      if (PKT_VALID_I && blocked) begin
        if (port_is_upstream) begin
          status_reg[PMIC_STS_PRI_BIT] <= 1'b1;
        end else begin
          status_reg[PMIC_STS_SEC_BIT] <= 1'b1;
        end
      end
    end
  end

  // saturating count of blocked packets
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      blocked_count_reg <= 16'h0000;
    end else if (PKT_VALID_I && blocked && blocked_count_reg != 16'hFFFF) begin
      blocked_count_reg <= blocked_count_reg + 16'h0001;
    end
  end

  // egress acceptance for packets from other ports
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      EG_DONE_O <= 1'b0;
      EG_ACCEPT_O <= 1'b0;
    end else begin
      EG_DONE_O <= EG_VALID_I;
      EG_ACCEPT_O <= EG_VALID_I && !EG_FROM_SELF_I && function_multicast_enable
                     && group_receive_vector[EG_GROUP_I];
    end
  end

  // checks
  sequence s_pkt_off;
    PKT_VALID_I && !multicast_global_enable;
  endsequence

  sequence s_pkt_noncand;
    PKT_VALID_I && !PKT_POSTED_MWR_I && !PKT_ADDR_MSG_I;
  endsequence

  sequence s_blocked_out;
    OUT_BLOCKED_O && OUT_DROP_O && CREDIT_RETURN_O;
  endsequence

  chk_disable_no_mc: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    s_pkt_off |=> !OUT_IS_MCAST_O && OUT_UNICAST_O)
    else $error("multicast seen while disabled");

  chk_type_filter: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    s_pkt_noncand |=> !OUT_IS_MCAST_O)
    else $error("non-candidate packet classified multicast");

  chk_unicast_route: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    OUT_VALID_O |-> (OUT_UNICAST_O != OUT_IS_MCAST_O))
    else $error("packet neither unicast nor multicast");

  chk_group_range: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    OUT_IS_MCAST_O |-> OUT_GROUP_O <= enabled_group_count)
    else $error("group outside enabled range");

  chk_block_all: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    OUT_IS_MCAST_O && !OUT_ACS_FAIL_O && group_block_all_bits[OUT_GROUP_O] |-> OUT_BLOCKED_O)
    else $error("block-all group not blocked");

  chk_blocked_drop: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    OUT_BLOCKED_O |-> s_blocked_out ##0 !OUT_MCAST_FWD_O)
    else $error("blocked packet not dropped");

  chk_blocked_report: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    OUT_BLOCKED_O |-> AER_MC_BLOCKED_O && HDR_LOG_O == $past(PKT_HDR_I))
    else $error("blocked packet not reported");

  chk_abort_flag: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    OUT_BLOCKED_O |-> (port_is_upstream ? status_reg[PMIC_STS_PRI_BIT] : status_reg[PMIC_STS_SEC_BIT]))
    else $error("target abort flag not set");

  chk_fwd_clean: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    OUT_MCAST_FWD_O |-> OUT_IS_MCAST_O && !OUT_BLOCKED_O && !OUT_ERR_O && !OUT_ACS_FAIL_O)
    else $error("faulty multicast forwarded");

  chk_in_order: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    PKT_VALID_I |=> OUT_VALID_O && OUT_ADDR_O == $past(PKT_ADDR_I))
    else $error("result out of order");

  chk_silent_drop: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    OUT_SILENT_DROP_O |-> OUT_DROP_O && !AER_MC_BLOCKED_O && !CREDIT_RETURN_O)
    else $error("unaccepted multicast not silent");

  chk_eg_accept: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    EG_ACCEPT_O |-> $past(function_multicast_enable) && !$past(EG_FROM_SELF_I))
    else $error("acceptance without enable");

  chk_block_untrans: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    OUT_IS_MCAST_O && !OUT_ACS_FAIL_O && group_block_untranslated_bits[OUT_GROUP_O]
      && $past(PKT_AT_I) == PMIC_AT_UNTRANSLATED |-> OUT_BLOCKED_O)
    else $error("untranslated packet not blocked");

  chk_acs_only: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    OUT_ACS_FAIL_O |-> OUT_IS_MCAST_O && !OUT_BLOCKED_O && !OUT_MCAST_FWD_O && !OUT_SILENT_DROP_O)
    else $error("source validation failure handled as block");

endmodule
`default_nettype wire

/* hdl/pmic_pkg.sv */
// How it works
// - up to 64 groups; capacity field resets to 32 groups, writable to 64
// - only posted memory writes and address-routed messages may be multicast
// - with the global enable clear nothing is multicast
// - non-multicast packets take the normal unicast route, unroutable as usual
// - group regions sit back to back from group zero, count set by field
// - each region spans two to the index position bytes
// - the 64-bit base joins the low and high base fields
// - clear low and group bits, compare with base; mismatch means unicast
// - group number is the bit length of the count field, from index position
// - group number beyond the enabled count means not multicast
// - only source validation access check applies; failure handled by that path
// - block-all bit of the group set means blocked
// - block-untranslated bit set and untranslated address means blocked
// - blocked packets are dropped and their credits returned
// - blocked packets raise the blocked error and log the header
// - blocked sets target abort flag, primary if upstream, secondary if downstream
// - block checks run at ingress; clean multicast goes on to egress
// - multicast keeps posted ordering; results leave in arrival order
// - malformed, poison and CRC checks apply to multicast like any packet
// - another function accepts only with its enable and receive bit set
// - a multicast packet nobody accepts is dropped silently
package pmic_pkg;
  localparam int PMIC_GROUPS = 64;
  // register byte offsets
  localparam logic [7:0] PMIC_OFF_CAP = 8'h00;
  localparam logic [7:0] PMIC_OFF_CTL = 8'h04;
  localparam logic [7:0] PMIC_OFF_BASE_LO = 8'h08;
  localparam logic [7:0] PMIC_OFF_BASE_HI = 8'h0C;
  localparam logic [7:0] PMIC_OFF_BLKALL_LO = 8'h10;
  localparam logic [7:0] PMIC_OFF_BLKALL_HI = 8'h14;
  localparam logic [7:0] PMIC_OFF_BLKUT_LO = 8'h18;
  localparam logic [7:0] PMIC_OFF_BLKUT_HI = 8'h1C;
  localparam logic [7:0] PMIC_OFF_RCV_LO = 8'h20;
  localparam logic [7:0] PMIC_OFF_RCV_HI = 8'h24;
  localparam logic [7:0] PMIC_OFF_FUNC = 8'h28;
  localparam logic [7:0] PMIC_OFF_STATUS = 8'h2C;
  localparam logic [7:0] PMIC_OFF_BLKCNT = 8'h30;
  // field positions
  localparam int PMIC_CTL_EN_BIT = 15;
  localparam int PMIC_BASE_LO_POS = 12;
  localparam int PMIC_FUNC_EN_BIT = 0;
  localparam int PMIC_FUNC_UP_BIT = 1;
  localparam int PMIC_STS_PRI_BIT = 0;
  localparam int PMIC_STS_SEC_BIT = 1;
  // reset values and untranslated address type code
  localparam logic [5:0] PMIC_CAP_RST = 6'h1F;
  localparam logic [5:0] PMIC_NG_RST = 6'h00;
  localparam logic [5:0] PMIC_IDX_RST = 6'h00;
  localparam logic [1:0] PMIC_AT_UNTRANSLATED = 2'h0;
endpackage

/* test/pmic_link_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module pmic_link_partner (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic send_i,
  input wire logic [1:0] kind_i,
  input wire logic [63:0] addr_i,
  input wire logic [1:0] at_i,
  input wire logic [2:0] cond_i,
  output logic valid_o,
  output logic posted_o,
  output logic msg_o,
  output logic [63:0] addr_o,
  output logic [1:0] at_o,
  output logic [127:0] hdr_o,
  output logic acs_o,
  output logic err_o,
  output logic others_o
);
  // one packet per send cycle; fields stop holding once it is gone
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {valid_o, posted_o, msg_o, acs_o, err_o, others_o} <= 6'h00;
      {addr_o, at_o, hdr_o} <= '0;
    end else if (send_i) begin
      {valid_o, posted_o, msg_o, at_o} <= {1'b1, kind_i, at_i};
      {acs_o, err_o, others_o} <= cond_i;
      addr_o <= addr_i;
      hdr_o <= {addr_i, ~addr_i};
    end else begin
      {valid_o, posted_o, msg_o, acs_o, err_o, others_o} <= 6'h00;
      addr_o <= ~addr_o;
      at_o <= ~at_o;
      hdr_o <= ~hdr_o;
    end
  end
endmodule
`default_nettype wire

/* test/pcie_multicast_ingress_classifier_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module pcie_multicast_ingress_classifier_bench
  import pmic_pkg::*;
;
  // expected flag sets: valid,mc,uc,fwd,blk,acs,err,silent,drop,credit,aer
  localparam logic [10:0] UC = 11'h500;
  localparam logic [10:0] MF = 11'h680;
  localparam logic [10:0] BL = 11'h647;
  localparam logic [10:0] AC = 11'h620;
  localparam logic [10:0] ER = 11'h610;
  localparam logic [10:0] SD = 11'h60C;
  localparam logic [63:0] BASE = 64'h0000_0001_0001_0000;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, send;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] kind, at, p_at;
  logic [63:0] addr, p_addr, o_addr;
  logic [2:0] cond;
  logic p_valid, p_posted, p_msg, p_acs, p_err, p_others, pkt_ready;
  logic o_valid, o_mc, o_uc, o_fwd, o_blk, o_acs, o_err, o_sd, o_drop, o_cr, o_aer;
  logic eg_v, eg_self, eg_done, eg_acc;
  logic [5:0] o_grp, eg_grp;
  logic [127:0] p_hdr, hdr_log;
  int mismatches, cmp_count;

  pmic_link_partner partner (.clk_i(clk), .rst_n_i(rst_n), .send_i(send), .kind_i(kind), .addr_i(addr),
    .at_i(at), .cond_i(cond), .valid_o(p_valid), .posted_o(p_posted), .msg_o(p_msg), .addr_o(p_addr),
    .at_o(p_at), .hdr_o(p_hdr), .acs_o(p_acs), .err_o(p_err), .others_o(p_others));

  pmic_classifier dut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PKT_VALID_I(p_valid), .PKT_READY_O(pkt_ready), .PKT_POSTED_MWR_I(p_posted),
    .PKT_ADDR_MSG_I(p_msg), .PKT_ADDR_I(p_addr), .PKT_AT_I(p_at), .PKT_HDR_I(p_hdr),
    .PKT_ACS_SV_FAIL_I(p_acs), .PKT_ERR_I(p_err), .OTHERS_ACCEPT_I(p_others), .OUT_VALID_O(o_valid),
    .OUT_ADDR_O(o_addr), .OUT_IS_MCAST_O(o_mc), .OUT_GROUP_O(o_grp), .OUT_UNICAST_O(o_uc),
    .OUT_MCAST_FWD_O(o_fwd), .OUT_BLOCKED_O(o_blk), .OUT_ACS_FAIL_O(o_acs), .OUT_ERR_O(o_err),
    .OUT_SILENT_DROP_O(o_sd), .OUT_DROP_O(o_drop), .CREDIT_RETURN_O(o_cr), .AER_MC_BLOCKED_O(o_aer),
    .HDR_LOG_O(hdr_log), .EG_VALID_I(eg_v), .EG_GROUP_I(eg_grp), .EG_FROM_SELF_I(eg_self),
    .EG_DONE_O(eg_done), .EG_ACCEPT_O(eg_acc));

  // 40 MHz reference clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // compare and count
  task chk(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one apb transfer: setup, then access until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      mismatches++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk(e, xe);
  endtask

  // address inside group g, offset 0x40
  function automatic logic [63:0] ga(input logic [5:0] g);
    return BASE + {46'h0, g, 12'h040};
  endfunction

  // one packet through the partner; result one cycle after it is taken
  task pkt(input logic [1:0] k, input logic [63:0] a, input logic [1:0] t, input logic [2:0] c,
      input logic [10:0] ef, input logic [5:0] eg);
    @(posedge clk);
    {send, kind, addr, at, cond} <= {1'b1, k, a, t, c};
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({o_valid, o_mc, o_uc, o_fwd, o_blk, o_acs, o_err, o_sd, o_drop, o_cr, o_aer}, ef);
    chk({o_grp, o_addr, pkt_ready}, {eg, a, 1'b1});
  endtask

  task egq(input logic [5:0] g, input logic s, input logic x);
    @(posedge clk);
    {eg_v, eg_grp, eg_self} <= {1'b1, g, s};
    @(posedge clk);
    eg_v <= 1'b0;
    @(negedge clk);
    chk({eg_done, eg_acc}, {1'b1, x});
  endtask

  task s_regs;
    rdc(PMIC_OFF_CAP, 32'h0000_001F, 1'b0);
    wr(PMIC_OFF_CAP, 32'h0000_003F);
    rdc(PMIC_OFF_CAP, 32'h0000_003F, 1'b0);
    wr(8'h3C, 32'hFFFF_FFFF);
    rdc(8'h3C, 32'h0, 1'b1);
    // routing fields set while no multicast traffic flows
    wr(PMIC_OFF_BASE_LO, 32'h0001_000C);
    wr(PMIC_OFF_BASE_HI, 32'h0000_0001);
    wr(PMIC_OFF_CTL, 32'h0000_0002);
    wr(PMIC_OFF_FUNC, 32'h0000_0003);
    pkt(2'b10, ga(6'h1), 2'h1, 3'b001, UC, 6'h0);
    wr(PMIC_OFF_CTL, 32'h0000_8002);
  endtask

  task s_classify;
    pkt(2'b10, ga(6'h0), 2'h1, 3'b001, MF, 6'h0);
    pkt(2'b10, BASE + 64'hFFF, 2'h1, 3'b001, MF, 6'h0);
    pkt(2'b10, BASE + 64'h1000, 2'h1, 3'b001, MF, 6'h1);
    pkt(2'b01, ga(6'h2), 2'h1, 3'b001, MF, 6'h2);
    pkt(2'b00, ga(6'h2), 2'h1, 3'b001, UC, 6'h0);
    pkt(2'b10, ga(6'h3), 2'h1, 3'b001, UC, 6'h0);
    pkt(2'b10, ga(6'h1) ^ 64'h1_0000_0000, 2'h1, 3'b001, UC, 6'h0);
    pkt(2'b10, ga(6'h1) | 64'h4000, 2'h1, 3'b001, UC, 6'h0);
  endtask

  task s_block;
    wr(PMIC_OFF_BLKALL_LO, 32'h0000_0004);
    pkt(2'b10, ga(6'h2), 2'h1, 3'b001, BL, 6'h2);
    chk(hdr_log, {ga(6'h2), ~ga(6'h2)});
    rdc(PMIC_OFF_STATUS, 32'h0000_0001, 1'b0);
    wr(PMIC_OFF_STATUS, 32'h0000_0001);
    rdc(PMIC_OFF_STATUS, 32'h0, 1'b0);
    wr(PMIC_OFF_BLKALL_LO, 32'h0);
    wr(PMIC_OFF_BLKUT_LO, 32'h0000_0002);
    pkt(2'b10, ga(6'h1), PMIC_AT_UNTRANSLATED, 3'b001, BL, 6'h1);
    pkt(2'b10, ga(6'h1), 2'h1, 3'b001, MF, 6'h1);
    wr(PMIC_OFF_FUNC, 32'h0000_0001);
    pkt(2'b10, ga(6'h1), PMIC_AT_UNTRANSLATED, 3'b001, BL, 6'h1);
    rdc(PMIC_OFF_STATUS, 32'h0000_0003, 1'b0);
    rdc(PMIC_OFF_BLKCNT, 32'h0000_0003, 1'b0);
  endtask

  task s_misc;
    pkt(2'b10, ga(6'h0), 2'h1, 3'b101, AC, 6'h0);
    pkt(2'b10, ga(6'h0), 2'h1, 3'b011, ER, 6'h0);
    pkt(2'b10, ga(6'h0), 2'h1, 3'b000, SD, 6'h0);
    wr(PMIC_OFF_RCV_LO, 32'h0000_0002);
    egq(6'h1, 1'b0, 1'b1);
    egq(6'h1, 1'b1, 1'b0);
    egq(6'h0, 1'b0, 1'b0);
    wr(PMIC_OFF_FUNC, 32'h0);
    egq(6'h1, 1'b0, 1'b0);
  endtask

  // two packets on consecutive cycles leave in arrival order
  task s_order;
    @(posedge clk);
    {send, kind, addr, at, cond} <= {1'b1, 2'b10, ga(6'h0), 2'h1, 3'b001};
    @(posedge clk);
    {kind, addr} <= {2'b01, ga(6'h2)};
    @(posedge clk);
    send <= 1'b0;
    @(negedge clk);
    chk({o_valid, o_grp, o_fwd}, {1'b1, 6'h0, 1'b1});
    @(negedge clk);
    chk({o_valid, o_grp, o_fwd}, {1'b1, 6'h2, 1'b1});
  endtask

  // reset, then the scenarios in turn
  initial begin
    {rst_n, psel, penable, pwrite, send, eg_v, eg_self} = 7'h00;
    {paddr, pwdata, kind, addr, at, cond, eg_grp} = '0;
    mismatches = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    s_regs();
    s_classify();
    s_block();
    s_misc();
    s_order();
    wrap_up();
  end
endmodule
`default_nettype wire
